// [logic/pm_control_status.sv]
// Power management control/status register reached by configuration accesses
`timescale 1ns/100ps
`include "pm_csr_map.svh"
module pm_control_status #(
    parameter bit HAS_DATA_REG = 1'b0,
    parameter bit D1_SUPPORT   = 1'b1,
    parameter bit D2_SUPPORT   = 1'b1
) (
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               por_n,
    input  wire logic               amber_led4_strap,
    input  wire logic               wake_event,
    input  wire logic [1:0]         data_scale_in,
    input  wire logic [7:0]         cfg_addr,
    input  wire logic               cfg_rd,
    input  wire logic               cfg_wr,
    input  wire logic [1:0]         cfg_be,
    input  wire logic [15:0]        cfg_wdata,
    output logic [15:0]             cfg_rdata,
    output logic                    cfg_ack,
    output pm_pkg::power_state_e    power_state,
    output logic [3:0]              data_select,
    output logic                    wake_from_cold_support,
    output logic                    pme_n
);
    import pm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    csr_state_s    cur;
    csr_state_s    next_cur;
    pm_wake_if     wb();

    logic          hit;
    logic          wr_lo;
    logic          wr_hi;
    logic [1:0]    req_ps;
    logic          ps_ok;
    logic [1:0]    scale_rd;
    logic [3:0]    dsel_rd;
    logic [15:0]   read_word;

    assign hit    = (cfg_addr == `PM_CSR_ADDR);
    assign wr_lo  = cfg_wr && hit && cfg_be[0];
    assign wr_hi  = cfg_wr && hit && cfg_be[1];
    assign req_ps = cfg_wdata[`PM_BIT_PS_HI:`PM_BIT_PS_LO];

    // D0 and D3hot are mandatory; D1 and D2 follow the build options
    always_comb begin
        unique case (power_state_e'(req_ps))
            PS_D1:   ps_ok = D1_SUPPORT;
            PS_D2:   ps_ok = D2_SUPPORT;
            PS_D0, PS_D3HOT: ps_ok = 1'b1;
        endcase
    end

    // Scale and select collapse to zero when no data register sits behind them
    assign scale_rd = HAS_DATA_REG ? data_scale_in : 2'h0;
    assign dsel_rd  = HAS_DATA_REG ? cur.data_select : `PM_RST_DSEL;

    // Reserved bits are not stored, so they always read back as their reset value
    assign read_word = {wb.status, scale_rd, dsel_rd, wb.enable,
                        `PM_RST_RESERVED, cur.power_state};

    ////////////////////////////////////////////////////////////////////////////////
    // Wake unit hookup

    assign wb.wake_event = nrst && wake_event;
    assign wb.clr_status = wr_hi && cfg_wdata[`PM_BIT_STATUS];
    assign wb.wr_enable  = wr_hi;
    assign wb.enable_val = cfg_wdata[`PM_BIT_ENABLE];
    assign wb.support    = cur.support;

    pm_wake_unit u_wake (
        .mclk  (mclk),
        .nrst  (nrst),
        .por_n (por_n),
        .wb    (wb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State

    always_comb begin
        next_cur       = cur;
        next_cur.ack   = 1'b0;
        if (!por_n) begin
            // Strap is caught while power-on reset is held, then frozen
            next_cur.support = amber_led4_strap;
        end
        if (!nrst || !por_n) begin
            next_cur.power_state = power_state_e'(`PM_RST_PS);
            next_cur.data_select = `PM_RST_DSEL;
            next_cur.rdata       = `PM_RST_RDATA;
        end else begin
            if (cfg_rd || cfg_wr) begin
                // Every access completes; unmapped addresses read zero
                next_cur.ack   = 1'b1;
                next_cur.rdata = (cfg_rd && hit) ? read_word : `PM_RST_RDATA;
            end
            if (wr_lo && ps_ok) begin
                next_cur.power_state = power_state_e'(req_ps);
            end
            if (wr_hi && HAS_DATA_REG) begin
                next_cur.data_select = cfg_wdata[`PM_BIT_DSEL_HI:`PM_BIT_DSEL_LO];
            end
        end
    end

    always_ff @(posedge mclk) begin
        cur <= next_cur;
    end

    assign cfg_rdata              = cur.rdata;
    assign cfg_ack                = cur.ack;
    assign power_state            = cur.power_state;
    assign data_select            = cur.data_select;
    assign wake_from_cold_support = cur.support;
    assign pme_n                  = wb.pme_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_PS_WRITE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wr_lo && ps_ok |=> power_state == power_state_e'($past(req_ps)))
        else $error("supported power state write not taken");

    AST_PS_DISCARD: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wr_lo && !ps_ok |=> $stable(power_state) && cfg_ack)
        else $error("unsupported state changed the field or was not acknowledged");

    AST_RESET_D0: assert property (@(posedge mclk) disable iff (!por_n)
        !nrst |=> power_state == PS_D0 && data_select == 4'h0 && !cfg_ack)
        else $error("reset did not return function to D0");

    AST_DSEL_STORE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        HAS_DATA_REG && wr_hi |=> data_select == $past(cfg_wdata[12:9]))
        else $error("data select write not stored");

    AST_NO_DATA_ZERO: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !HAS_DATA_REG && cfg_ack |-> cfg_rdata[14:9] == 6'h00)
        else $error("scale or select nonzero without data register");

    AST_SCALE_RO: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        HAS_DATA_REG && cfg_rd && hit |=> cfg_rdata[14:13] == $past(data_scale_in))
        else $error("data scale does not report the scaling input");

    AST_STRAP: assert property (@(posedge mclk)
        !por_n |=> wake_from_cold_support == $past(amber_led4_strap))
        else $error("strap not captured at power-on");

    AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (!por_n)
        $past(por_n) |-> $stable(wake_from_cold_support))
        else $error("cold-wake support changed after power-on");

    AST_READ_STATUS: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_rd && hit |=> cfg_ack && cfg_rdata[15] == $past(wb.status)
            && cfg_rdata[8] == $past(wb.enable) && cfg_rdata[7:2] == 6'h00)
        else $error("read word does not show status and enable");

    AST_ACK_EVERY: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_rd || cfg_wr |=> cfg_ack)
        else $error("access was not acknowledged");

    AST_ACK_IDLE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !cfg_rd && !cfg_wr |=> !cfg_ack)
        else $error("acknowledge seen without an access");

    AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_rd && !hit |=> cfg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");

    AST_UNMAPPED_WRITE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_wr && !hit |=> $stable(power_state) && $stable(data_select))
        else $error("unmapped write changed a field");

    AST_PS_HOLD: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !wr_lo |=> $stable(power_state))
        else $error("power state changed without a write");

    AST_PS_READ: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_rd && hit |=> cfg_rdata[1:0] == $past(power_state))
        else $error("read word does not show the power state");

    AST_DSEL_HOLD: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !wr_hi |=> $stable(data_select))
        else $error("data select changed without a write");

    AST_DSEL_READ: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_rd && hit |=> cfg_rdata[12:9] == $past(data_select))
        else $error("read word does not show the data select");

    AST_DSEL_ZERO: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !HAS_DATA_REG |-> data_select == 4'h0)
        else $error("data select nonzero without data register");

    AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !cfg_rd && !cfg_wr |=> $stable(cfg_rdata))
        else $error("read data changed without an access");

    AST_WR_RDATA_ZERO: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        cfg_wr && !cfg_rd |=> cfg_rdata == 16'h0000)
        else $error("write answered with nonzero read data");

    AST_RESET_RDATA: assert property (@(posedge mclk) disable iff (!por_n)
        !nrst |=> cfg_rdata == 16'h0000)
        else $error("reset did not clear read data");

    AST_PS_LEGAL: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        (power_state != PS_D1 || D1_SUPPORT) && (power_state != PS_D2 || D2_SUPPORT))
        else $error("power state holds an unsupported value");

    AST_CLR_RELEASE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wb.clr_status && !wb.wake_event |=> pme_n)
        else $error("wake output still asserted after clear");

    AST_ENABLE_WRITE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wr_hi |=> wb.enable == $past(cfg_wdata[8]))
        else $error("wake enable write not stored");

endmodule // pm_control_status

// [logic/pm_csr_map.svh]
// Offsets, field positions and reset values of the power management control/status register
`ifndef PM_CSR_MAP_SVH
`define PM_CSR_MAP_SVH

`define PM_CSR_ADDR         8'h38
`define PM_BIT_STATUS       15
`define PM_BIT_SCALE_HI     14
`define PM_BIT_SCALE_LO     13
`define PM_BIT_DSEL_HI      12
`define PM_BIT_DSEL_LO      9
`define PM_BIT_ENABLE       8
`define PM_BIT_PS_HI        1
`define PM_BIT_PS_LO        0
`define PM_RST_PS           2'h0
`define PM_RST_DSEL         4'h0
`define PM_RST_RESERVED     6'h00
`define PM_RST_RDATA        16'h0000

`endif

// [logic/pm_pkg.sv]
// Types shared by the power management control/status logic
package pm_pkg;

    typedef enum logic [1:0] {
        PS_D0,
        PS_D1,
        PS_D2,
        PS_D3HOT
    } power_state_e;

    typedef struct packed {
        logic          status;
        logic          enable;
        logic          pme_n;
    } wake_state_s;

    typedef struct packed {
        power_state_e  power_state;
        logic [3:0]    data_select;
        logic          support;
        logic [15:0]   rdata;
        logic          ack;
    } csr_state_s;

endpackage

// [logic/pm_wake_if.sv]
// Carrier between the register decode and the wake event unit
`timescale 1ns/100ps
interface pm_wake_if;
    logic wake_event;
    logic clr_status;
    logic wr_enable;
    logic enable_val;
    logic support;
    logic status;
    logic enable;
    logic pme_n;

    modport csr  (output wake_event, clr_status, wr_enable, enable_val, support,
                  input  status, enable, pme_n);
    modport wake (input  wake_event, clr_status, wr_enable, enable_val, support,
                  output status, enable, pme_n);
endinterface

// [logic/pm_wake_unit.sv]
// Wake event status, wake enable and the active-low wake output
`timescale 1ns/100ps
module pm_wake_unit (
    input  wire logic   mclk,
    input  wire logic   nrst,
    input  wire logic   por_n,
    pm_wake_if.wake     wb
);
    import pm_pkg::*;

    wake_state_s cur;
    wake_state_s next_cur;

    always_comb begin
        next_cur = cur;
        if (!por_n) begin
            next_cur = '{status: 1'b0, enable: 1'b0, pme_n: 1'b1};
        end else if (!nrst && !wb.support) begin
            next_cur = '{status: 1'b0, enable: 1'b0, pme_n: 1'b1};
        end else if (nrst) begin
            // Set beats clear so an event in the clearing cycle is kept
            next_cur.status = (cur.status & ~wb.clr_status) | wb.wake_event;
            if (wb.wr_enable) begin
                next_cur.enable = wb.enable_val;
            end
            next_cur.pme_n = ~(next_cur.status & next_cur.enable);
        end
    end

    always_ff @(posedge mclk) begin
        cur <= next_cur;
    end

    assign wb.status = cur.status;
    assign wb.enable = cur.enable;
    assign wb.pme_n  = cur.pme_n;

    AST_STATUS_SET: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wb.wake_event |=> wb.status)
        else $error("wake event did not set status");

    AST_STATUS_CLR: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wb.clr_status && !wb.wake_event |=> !wb.status)
        else $error("write of one did not clear status");

    AST_PME_GATE: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        wb.pme_n == !(wb.status && wb.enable))
        else $error("wake output disagrees with status and enable");

    AST_PME_SUPPRESS: assert property (@(posedge mclk) disable iff (!nrst || !por_n)
        !wb.enable |-> wb.pme_n)
        else $error("wake output asserted while disabled");

    AST_STICKY: assert property (@(posedge mclk) disable iff (!por_n)
        !nrst && $past(nrst) && wb.support |=> wb.status == $past(wb.status)
            && wb.enable == $past(wb.enable))
        else $error("sticky bits lost across function reset");

    AST_NOT_STICKY: assert property (@(posedge mclk) disable iff (!por_n)
        !nrst && !wb.support |=> !wb.status && !wb.enable)
        else $error("bits not cleared by reset without cold-wake support");

endmodule // pm_wake_unit

// [sim/cfg_host_model.sv]
// Configuration host model driving the register bus
`timescale 1ns/100ps
module cfg_host_model (
    input  wire logic        mclk,
    output logic [7:0]       cfg_addr,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [1:0]       cfg_be,
    output logic [15:0]      cfg_wdata,
    input  wire logic [15:0] cfg_rdata,
    input  wire logic        cfg_ack
);
    initial begin
        cfg_addr = 8'h00;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_be = 2'h0;
        cfg_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle request; the answer is taken in the cycle after the taking edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                          output logic ack, output logic [15:0] rd);
        @(posedge mclk);
        #1;
        cfg_addr = addr;
        cfg_be = 2'h3;
        cfg_wdata = wd & 16'hFF03; // Reserved bits go out as zero
        cfg_rd = !wr;
        cfg_wr = wr;
        @(posedge mclk);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        cfg_addr = ~cfg_addr;
        cfg_wdata = ~cfg_wdata;
        ack = cfg_ack;
        rd = cfg_rdata;
    endtask
    // Boot-time clean-up of the sticky bits
    task automatic os_boot(output logic ack);
        logic [15:0] d;
        access(1'b1, 8'h38, 16'h8000, ack, d);
    endtask
endmodule // cfg_host_model

// [sim/tb_top.sv]
// Self-checking bench for the power management control/status register
`timescale 1ns/100ps
module tb_top;
    logic        mclk, nrst, por_n, strap, wake_event, cfg_rd, cfg_wr, cfg_ack;
    logic        support, pme_n, a;
    logic [7:0]  cfg_addr;
    logic [1:0]  cfg_be;
    logic [15:0] cfg_wdata, cfg_rdata, d;
    logic [3:0]  data_select;
    logic [3:0]  dsel_dr;
    logic [1:0]  scale;
    logic [15:0] rdata_dr;
    logic        ack_dr;
    pm_pkg::power_state_e power_state;
    int          error_cnt = 0;
    int          n_compared = 0;
    // D2 left out so a write of an unsupported state can be tried
    pm_control_status #(.D2_SUPPORT(1'b0)) pm_control_status_i (
        .mclk(mclk), .nrst(nrst), .por_n(por_n), .amber_led4_strap(strap),
        .wake_event(wake_event), .data_scale_in(scale), .cfg_addr(cfg_addr),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .power_state(power_state),
        .data_select(data_select), .wake_from_cold_support(support), .pme_n(pme_n));
    // Second copy with the data register present, fed the same bus
    if (1) begin : with_data
        pm_control_status #(.HAS_DATA_REG(1'b1)) pm_control_status_i (
            .mclk(mclk), .nrst(nrst), .por_n(por_n), .amber_led4_strap(strap),
            .wake_event(wake_event), .data_scale_in(scale), .cfg_addr(cfg_addr),
            .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
            .cfg_rdata(rdata_dr), .cfg_ack(ack_dr), .power_state(),
            .data_select(dsel_dr), .wake_from_cold_support(), .pme_n());
    end
    cfg_host_model cfg_host_model_i (
        .mclk(mclk), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic rw(input logic wr, input logic [15:0] wd, input logic [15:0] exp);
        cfg_host_model_i.access(wr, 8'h38, wd, a, d);
        chk({15'h0, a}, 16'h0001);
        if (!wr) chk(d, exp);
    endtask
    task automatic pulse(input logic w, input logic p);
        @(posedge mclk);
        #1;
        wake_event = w;
        nrst = !p;
        @(posedge mclk);
        #1;
        wake_event = 1'b0;
        nrst = 1'b1;
    endtask
    task automatic power_on(input logic s);
        @(posedge mclk);
        #1;
        strap = s;
        por_n = 1'b0;
        nrst = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        por_n = 1'b1;
        nrst = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_state;
        logic [1:0] req[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [1:0] exp[4] = '{2'h1, 2'h1, 2'h3, 2'h0};
        for (int i = 0; i < 4; i++) begin
            rw(1'b1, {14'h0, req[i]}, 16'h0);
            chk({14'h0, power_state}, {14'h0, exp[i]});
            rw(1'b0, 16'h0, {14'h0, exp[i]});
        end
    endtask
    task automatic t_wake;
        pulse(1'b1, 1'b0);
        chk({15'h0, pme_n}, 16'h0001);
        rw(1'b0, 16'h0, 16'h8000);
        rw(1'b1, 16'h0100, 16'h0);
        chk({15'h0, pme_n}, 16'h0000);
        rw(1'b0, 16'h0, 16'h8100);
        rw(1'b1, 16'h8100, 16'h0);
        chk({15'h0, pme_n}, 16'h0001);
        rw(1'b0, 16'h0, 16'h0100);
        // Event in the same cycle as the clear: the set must win
        wake_event = 1'b1;
        rw(1'b1, 16'h8100, 16'h0);
        wake_event = 1'b0;
        chk({15'h0, pme_n}, 16'h0000);
        rw(1'b0, 16'h0, 16'h8100);
        rw(1'b1, 16'h8100, 16'h0);
    endtask
    task automatic t_sticky;
        pulse(1'b1, 1'b0);
        rw(1'b1, 16'h0103, 16'h0);
        pulse(1'b0, 1'b1);
        rw(1'b0, 16'h0, 16'h8100);
        power_on(1'b0);
        chk({15'h0, support}, 16'h0000);
        rw(1'b1, 16'h0100, 16'h0);
        pulse(1'b1, 1'b0);
        rw(1'b0, 16'h0, 16'h8100);
        pulse(1'b0, 1'b1);
        rw(1'b0, 16'h0, 16'h0000);
    endtask
    task automatic t_data;
        rw(1'b1, 16'h7E00, 16'h0);
        chk({12'h0, data_select}, 16'h0000);
        chk({12'h0, dsel_dr}, 16'h000F);
        rw(1'b0, 16'h0, 16'h0000);
        chk(rdata_dr, 16'h5E00);
        chk({15'h0, ack_dr}, 16'h0001);
        cfg_host_model_i.access(1'b0, 8'h3C, 16'h0, a, d);
        chk({a, d[14:0]}, 16'h8000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        // Resets are low from time zero so no check sees unknown state
        wake_event = 1'b0;
        scale      = 2'h2;
        strap      = 1'b1;
        por_n      = 1'b0;
        nrst       = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        por_n = 1'b1;
        nrst  = 1'b1;
        chk({15'h0, support}, 16'h0001);
        rw(1'b0, 16'h0, 16'h0000);
        cfg_host_model_i.os_boot(a);
        t_state();
        t_wake();
        t_sticky();
        t_data();
        give_verdict();
    end
endmodule // tb_top
